/* inc/rcf_params.svh */
// constants of the reset cause flag bank: register indices, bit positions, reset values
// assumes AHB-Lite word addressing: byte address is four times the register index
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH

// register indices (byte address = index * 4)
`define RCF_IDX_BROWNOUT_CONTROL 12'h0811
`define RCF_IDX_CAUSE_MAIN       12'h0813
`define RCF_IDX_CAUSE_EXTRA      12'h0814
`define RCF_IDX_IRQ_STATUS       12'h0815
`define RCF_IDX_IRQ_MASK         12'h0816

// brownout_control fields
`define RCF_BIT_SW_BROWNOUT_ENABLE 7
`define RCF_BIT_BROWNOUT_READY     0

// reset_cause_main fields; the irq status and mask share this layout plus mem_violation_cause_n in bit 5
`define RCF_BIT_STACK_OVERFLOW   7
`define RCF_BIT_STACK_UNDERFLOW  6
`define RCF_BIT_MEM_VIOLATION    5
`define RCF_BIT_WATCHDOG_N       4
`define RCF_BIT_PIN_N            3
`define RCF_BIT_INSTR_N          2
`define RCF_BIT_POWERON_N        1
`define RCF_BIT_BROWNOUT_N       0

// reset_cause_extra fields
`define RCF_BIT_MEM_VIOLATION_CAUSE_N_N 1

// brownout mode configuration codes
`define RCF_BOMODE_OFF      2'h0
`define RCF_BOMODE_SOFTWARE 2'h1

// values after power-on of the block
`define RCF_RST_SW_BROWNOUT 1'h1
`define RCF_RST_STACK_FLAG  1'h0
`define RCF_RST_CAUSE_N     1'h1
`define RCF_RST_POWERON_N   1'h0
`define RCF_RST_IRQ_MASK    8'h00

`endif

/* inc/rcf_pkg.sv */
// types of the reset cause flag bank
// assumes rcf_params.svh carries the numeric constants
package rcf_pkg;

  // bus data phase state, gray along idle -> write and idle -> read
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10
  } rcf_phase_t;

  typedef logic [11:0] rcf_index_t;

endpackage

/* verilog/rcf_reset_cause_flags.sv */
// reset cause flag bank: records why the device restarted, AHB-Lite register slave
// assumes cause pulses arrive from the reset generator, synchronous to core_clk,
// while the system reset is still asserted; resetn is the block's power-on reset
//
// How it works
// - watchdog, pin, instruction and violation pulses update only their own flag; power-on and brownout also reload other flags.
// - software may write flags inactive; hardware makes them inactive only on power-on or brownout.
// - software may write flags active; only storage changes, no reset requested.
// - sw brownout enable drives the detector only in mode 01; else inert.
// - sw brownout enable loads 1 on power-on or brownout, kept otherwise.
// - bit 0 brownout ready reads 1 only when detector enabled and armed.
// - stack overflow flag set by hardware, cleared on power-on or brownout.
// - stack underflow flag set by hardware, cleared on power-on or brownout.
// - watchdog flag driven 0 on watchdog reset, 1 on power-on or brownout.
// - pin flag driven 0 on external pin reset, 1 on power-on or brownout.
// - instruction flag driven 0 on reset instruction, 1 on power-on or brownout.
// - power-on flag driven 0 on power-on, kept across other resets.
// - brownout flag driven 0 on brownout reset, kept across other resets.
// - memory violation flag driven 0 on violation, 1 on power-on or brownout.
// - stack events request a reset only while stack reset enable is set.
// - mode 00 keeps the brownout detector off whatever the enable bit says.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "rcf_params.svh"

module rcf_reset_cause_flags #(
  parameter int HADDR_W = 32
) (
  input  wire logic               core_clk,               // system clock, 125 MHz
  input  wire logic               resetn,                 // async power-on reset, low
  input  wire logic               hsel,                   // slave select
  input  wire logic [HADDR_W-1:0] haddr,                  // byte address
  input  wire logic [1:0]         htrans,                 // transfer type
  input  wire logic               hwrite,                 // write when high
  input  wire logic [2:0]         hsize,                  // transfer size, word only
  input  wire logic               hready,                 // bus ready
  input  wire logic [31:0]        hwdata,                 // write data
  output logic      [31:0]        hrdata,                 // read data
  output logic                    hreadyout,              // slave ready
  output logic                    hresp,                  // always OKAY
  input  wire logic               causePowerOn,           // power-on reset pulse
  input  wire logic               causeBrownout,          // brownout reset pulse
  input  wire logic               causeWatchdog,          // watchdog time-out reset pulse
  input  wire logic               causePin,               // external reset pin pulse
  input  wire logic               causeInstr,             // reset instruction pulse
  input  wire logic               causeMemViolation,      // memory violation reset pulse
  input  wire logic               stackOverflowEvent,     // more calls than stack depth
  input  wire logic               stackUnderflowEvent,    // more returns than calls
  input  wire logic               stackResetEnable,       // configuration enable
  input  wire logic [1:0]         brownoutModeConfig,     // brownout mode configuration
  input  wire logic               brownoutArmed,          // detector warmed up
  output logic                    brownoutDetectorEnable, // enable to the detector
  output logic                    stackResetRequest,      // reset request to generator
  output logic                    irq                     // level interrupt, high
);

  // the register index is cut from haddr bits 13:2
  if (HADDR_W < 14) begin : g_haddr_check
    $error("rcf_reset_cause_flags: HADDR_W must be at least 14");
  end

  // register file
  logic       swBrownoutEnable_reg;
  logic       stackOverflowFlag_reg;
  logic       stackUnderflowFlag_reg;
  logic       watchdogCauseN_reg;
  logic       pinCauseN_reg;
  logic       instrCauseN_reg;
  logic       powerOnCauseN_reg;
  logic       brownoutCauseN_reg;
  logic       memViolationCauseN_reg;
  logic [7:0] irqStatus_reg;
  logic [7:0] irqMask_reg;

  // bus phase
  rcf_pkg::rcf_phase_t phase_reg;
  rcf_pkg::rcf_phase_t phase_next;
  rcf_pkg::rcf_index_t wrIndex_reg;
  logic [31:0]         rdata_next;
  logic [7:0]          irqEvents;
  logic                addrValid;
  logic                rdTake;
  logic                powerReset;
  logic                wrControl;
  logic                wrMain;
  logic                wrExtra;
  logic                wrMask;
  logic                readStatus;

  function automatic rcf_pkg::rcf_index_t indexOf(input logic [HADDR_W-1:0] a);
    indexOf = a[13:2];
  endfunction

  function automatic logic [7:0] mainValue(
    input logic ovf,
    input logic unf,
    input logic wdtN,
    input logic pinN,
    input logic insN,
    input logic porN,
    input logic borN
  );
    mainValue = {ovf, unf, 1'b0, wdtN, pinN, insN, porN, borN};
  endfunction

  // a write lands at the edge that ends its data phase
  function automatic logic writeHit(
    input rcf_pkg::rcf_phase_t ph,
    input rcf_pkg::rcf_index_t at,
    input rcf_pkg::rcf_index_t idx
  );
    writeHit = (ph == rcf_pkg::PH_WRITE) && (at == idx);
  endfunction

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addrValid  = hsel && hready && htrans[1];
  assign rdTake     = addrValid && !hwrite;
  assign powerReset = causePowerOn || causeBrownout;

  assign wrControl = writeHit(phase_reg, wrIndex_reg, `RCF_IDX_BROWNOUT_CONTROL);
  assign wrMain    = writeHit(phase_reg, wrIndex_reg, `RCF_IDX_CAUSE_MAIN);
  assign wrExtra   = writeHit(phase_reg, wrIndex_reg, `RCF_IDX_CAUSE_EXTRA);
  assign wrMask    = writeHit(phase_reg, wrIndex_reg, `RCF_IDX_IRQ_MASK);
  assign readStatus = rdTake && (indexOf(haddr) == `RCF_IDX_IRQ_STATUS);

  // data phase sequencing
  always_comb begin
    phase_next = rcf_pkg::PH_IDLE;
    if (addrValid) begin
      phase_next = hwrite ? rcf_pkg::PH_WRITE : rcf_pkg::PH_READ;
    end
  end

  // hwdata follows its address by one cycle, so the index waits here
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg   <= rcf_pkg::PH_IDLE;
      wrIndex_reg <= 12'h000;
    end else begin
      phase_reg <= phase_next;
      if (addrValid) begin
        wrIndex_reg <= indexOf(haddr);
      end
    end
  end

  // read mux, registered at the address phase so hrdata stands in the data phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (indexOf(haddr))
      `RCF_IDX_BROWNOUT_CONTROL: begin
        rdata_next[`RCF_BIT_SW_BROWNOUT_ENABLE] = swBrownoutEnable_reg;
        rdata_next[`RCF_BIT_BROWNOUT_READY] = brownoutDetectorEnable && brownoutArmed;
      end
      `RCF_IDX_CAUSE_MAIN: begin
        rdata_next[7:0] = mainValue(stackOverflowFlag_reg, stackUnderflowFlag_reg,
                                    watchdogCauseN_reg, pinCauseN_reg, instrCauseN_reg,
                                    powerOnCauseN_reg, brownoutCauseN_reg);
      end
      `RCF_IDX_CAUSE_EXTRA: begin
        rdata_next[`RCF_BIT_MEM_VIOLATION_CAUSE_N_N] = memViolationCauseN_reg;
      end
      `RCF_IDX_IRQ_STATUS: begin
        rdata_next[7:0] = irqStatus_reg;
      end
      `RCF_IDX_IRQ_MASK: begin
        rdata_next[7:0] = irqMask_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rdTake) begin
      hrdata <= rdata_next;
    end
  end

  // brownout enable and detector control
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swBrownoutEnable_reg <= `RCF_RST_SW_BROWNOUT;
    end else if (powerReset) begin
      swBrownoutEnable_reg <= 1'b1;
    end else if (wrControl) begin
      swBrownoutEnable_reg <= hwdata[`RCF_BIT_SW_BROWNOUT_ENABLE];
    end
  end

  always_comb begin
    if (brownoutModeConfig == `RCF_BOMODE_SOFTWARE) begin
      brownoutDetectorEnable = swBrownoutEnable_reg;
    end else if (brownoutModeConfig == `RCF_BOMODE_OFF) begin
      brownoutDetectorEnable = 1'b0;
    // modes 10 and 11 keep the detector on
    end else begin
      brownoutDetectorEnable = 1'b1;
    end
  end

  assign stackResetRequest = stackResetEnable && (stackOverflowEvent || stackUnderflowEvent);

  // stack flags: hardware sets win over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stackOverflowFlag_reg <= `RCF_RST_STACK_FLAG;
    end else if (powerReset) begin
      stackOverflowFlag_reg <= 1'b0;
    end else if (stackOverflowEvent) begin
      stackOverflowFlag_reg <= 1'b1;
    end else if (wrMain) begin
      stackOverflowFlag_reg <= hwdata[`RCF_BIT_STACK_OVERFLOW];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stackUnderflowFlag_reg <= `RCF_RST_STACK_FLAG;
    end else if (powerReset) begin
      stackUnderflowFlag_reg <= 1'b0;
    end else if (stackUnderflowEvent) begin
      stackUnderflowFlag_reg <= 1'b1;
    end else if (wrMain) begin
      stackUnderflowFlag_reg <= hwdata[`RCF_BIT_STACK_UNDERFLOW];
    end
  end

  // own cause, set inactive again by power-on or brownout
  // active-low cause flags: the recorded cause wins over a software write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      watchdogCauseN_reg <= `RCF_RST_CAUSE_N;
    end else if (causeWatchdog) begin
      watchdogCauseN_reg <= 1'b0;
    end else if (powerReset) begin
      watchdogCauseN_reg <= 1'b1;
    end else if (wrMain) begin
      watchdogCauseN_reg <= hwdata[`RCF_BIT_WATCHDOG_N];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinCauseN_reg <= `RCF_RST_CAUSE_N;
    end else if (causePin) begin
      pinCauseN_reg <= 1'b0;
    end else if (powerReset) begin
      pinCauseN_reg <= 1'b1;
    end else if (wrMain) begin
      pinCauseN_reg <= hwdata[`RCF_BIT_PIN_N];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      instrCauseN_reg <= `RCF_RST_CAUSE_N;
    end else if (causeInstr) begin
      instrCauseN_reg <= 1'b0;
    end else if (powerReset) begin
      instrCauseN_reg <= 1'b1;
    end else if (wrMain) begin
      instrCauseN_reg <= hwdata[`RCF_BIT_INSTR_N];
    end
  end

  // only a power-on clears it; a brownout leaves it as it was
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      powerOnCauseN_reg <= `RCF_RST_POWERON_N;
    end else if (causePowerOn) begin
      powerOnCauseN_reg <= 1'b0;
    end else if (wrMain) begin
      powerOnCauseN_reg <= hwdata[`RCF_BIT_POWERON_N];
    end
  end

  // the block reset stands for power-on, so this flag starts inactive
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brownoutCauseN_reg <= `RCF_RST_CAUSE_N;
    end else if (causeBrownout) begin
      brownoutCauseN_reg <= 1'b0;
    end else if (wrMain) begin
      brownoutCauseN_reg <= hwdata[`RCF_BIT_BROWNOUT_N];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      memViolationCauseN_reg <= `RCF_RST_CAUSE_N;
    end else if (causeMemViolation) begin
      memViolationCauseN_reg <= 1'b0;
    end else if (powerReset) begin
      memViolationCauseN_reg <= 1'b1;
    end else if (wrExtra) begin
      memViolationCauseN_reg <= hwdata[`RCF_BIT_MEM_VIOLATION_CAUSE_N_N];
    end
  end

  always_comb begin
    irqEvents                           = 8'h00;
    irqEvents[`RCF_BIT_STACK_OVERFLOW]  = stackOverflowEvent;
    irqEvents[`RCF_BIT_STACK_UNDERFLOW] = stackUnderflowEvent;
    irqEvents[`RCF_BIT_MEM_VIOLATION]   = causeMemViolation;
    irqEvents[`RCF_BIT_WATCHDOG_N]      = causeWatchdog;
    irqEvents[`RCF_BIT_PIN_N]           = causePin;
    irqEvents[`RCF_BIT_INSTR_N]         = causeInstr;
    irqEvents[`RCF_BIT_POWERON_N]       = causePowerOn;
    irqEvents[`RCF_BIT_BROWNOUT_N]      = causeBrownout;
  end

  // sticky status, cleared by a read, a new event in the same cycle survives
  // the clear is taken in the address phase, so the read returns what it clears
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_reg <= 8'h00;
    end else if (readStatus) begin
      irqStatus_reg <= irqEvents;
    end else begin
      irqStatus_reg <= irqStatus_reg | irqEvents;
    end
  end

  // mask shares the status layout
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqMask_reg <= `RCF_RST_IRQ_MASK;
    end else if (wrMask) begin
      irqMask_reg <= hwdata[7:0];
    end
  end

  // registered, so a clearing read cannot glitch the level
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

endmodule

/* testbench/rcf_reset_cause_flags_props.sv */
// checker of the reset cause flag bank, bound to its top module
// assumes the bank is the only AHB-Lite slave, so hready follows hreadyout
`timescale 1ns/10ps
`include "rcf_params.svh"

module rcf_reset_cause_flags_props #(
  parameter int HADDR_W = 32
) (
  input wire logic               core_clk,               // clock
  input wire logic               resetn,                 // reset, low
  input wire logic               hsel,                   // select
  input wire logic [HADDR_W-1:0] haddr,                  // address
  input wire logic [1:0]         htrans,                 // transfer type
  input wire logic               hwrite,                 // write
  input wire logic               hready,                 // bus ready
  input wire logic [31:0]        hrdata,                 // read data
  input wire logic               causePowerOn,           // power-on pulse
  input wire logic               causeBrownout,          // brownout pulse
  input wire logic               causeWatchdog,          // watchdog pulse
  input wire logic               stackOverflowEvent,     // overflow
  input wire logic               stackUnderflowEvent,    // underflow
  input wire logic               stackResetEnable,       // stack reset config
  input wire logic [1:0]         brownoutModeConfig,     // mode config
  input wire logic               brownoutArmed,          // detector armed
  input wire logic               brownoutDetectorEnable, // detector enable
  input wire logic               stackResetRequest       // reset request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic rdTaken;
  logic wrTaken;
  logic rdMain;
  logic rdCtrl;
  logic stackEvt;
  assign rdTaken  = hsel && hready && htrans[1] && !hwrite;
  assign wrTaken  = hsel && hready && htrans[1] && hwrite;
  assign rdMain   = rdTaken && haddr[13:2] == `RCF_IDX_CAUSE_MAIN;
  assign rdCtrl   = rdTaken && haddr[13:2] == `RCF_IDX_BROWNOUT_CONTROL;
  assign stackEvt = stackOverflowEvent || stackUnderflowEvent;

  mode_off_a: assert property (
    brownoutModeConfig == `RCF_BOMODE_OFF |-> !brownoutDetectorEnable)
    else $error("detector enabled in mode off");
  ready_bit_a: assert property (
    rdCtrl |=> hrdata[0] == $past(brownoutDetectorEnable && brownoutArmed)
      && hrdata[31:8] == 24'h00_0000)
    else $error("ready status wrong");
  sw_enable_a: assert property (
    rdCtrl && brownoutModeConfig == `RCF_BOMODE_SOFTWARE
      |=> hrdata[7] == $past(brownoutDetectorEnable))
    else $error("detector not following enable bit");
  stack_gate_a: assert property (
    !stackResetEnable |-> !stackResetRequest)
    else $error("stack reset while disabled");
  stack_fire_a: assert property (
    stackResetEnable && stackEvt |-> stackResetRequest)
    else $error("stack reset missing");
  sw_write_a: assert property (
    wrTaken ##1 !stackEvt |-> !stackResetRequest)
    else $error("reset requested by a write");
  wdt_flag_a: assert property (
    causeWatchdog ##2 rdMain |=> !hrdata[`RCF_BIT_WATCHDOG_N])
    else $error("watchdog flag not recorded");
  ovf_flag_a: assert property (
    stackOverflowEvent && !causeBrownout && !causePowerOn ##2 rdMain
      |=> hrdata[`RCF_BIT_STACK_OVERFLOW])
    else $error("overflow flag not recorded");
  por_flag_a: assert property (
    causePowerOn ##2 rdMain |=> !hrdata[`RCF_BIT_POWERON_N])
    else $error("power-on flag not recorded");

  cover property (causeWatchdog ##2 rdMain);
  cover property (stackResetEnable && stackEvt);
  cover property (rdCtrl && brownoutModeConfig == `RCF_BOMODE_SOFTWARE);
endmodule

bind rcf_reset_cause_flags rcf_reset_cause_flags_props #(.HADDR_W(HADDR_W)) u_props (
  .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .causePowerOn(causePowerOn),
  .causeBrownout(causeBrownout), .causeWatchdog(causeWatchdog),
  .stackOverflowEvent(stackOverflowEvent), .stackUnderflowEvent(stackUnderflowEvent),
  .stackResetEnable(stackResetEnable), .brownoutModeConfig(brownoutModeConfig),
  .brownoutArmed(brownoutArmed), .brownoutDetectorEnable(brownoutDetectorEnable),
  .stackResetRequest(stackResetRequest)
);

/* testbench/rcf_reset_cause_flags_tb_top.sv */
// self-checking bench of the reset cause flag bank
// assumes the bank is the only AHB-Lite slave and answers without wait states
`timescale 1ns/10ps
`include "rcf_params.svh"

module rcf_reset_cause_flags_tb_top;
  localparam logic [31:0] A_CTRL  = {18'h0_0000, `RCF_IDX_BROWNOUT_CONTROL, 2'h0};
  localparam logic [31:0] A_MAIN  = {18'h0_0000, `RCF_IDX_CAUSE_MAIN, 2'h0};
  localparam logic [31:0] A_EXTRA = {18'h0_0000, `RCF_IDX_CAUSE_EXTRA, 2'h0};
  localparam logic [31:0] A_STAT  = {18'h0_0000, `RCF_IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] A_MASK  = {18'h0_0000, `RCF_IDX_IRQ_MASK, 2'h0};
  localparam logic [31:0] A_NONE  = {18'h0_0000, 12'h0812, 2'h0};

  logic        core_clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [7:0]  pulse;
  logic        stackResetEnable;
  logic [1:0]  modeCfg;
  logic        armed;
  logic        detEnable;
  logic        irq;
  logic        hresp;
  logic        stackReq;
  int          n_fail;
  int          n_tests;
  int          cycles;
  // pre main, pre extra, cause pulses (status layout), expected main, expected extra
  logic [39:0] rows [12] = '{40'h1F02_809F_02, 40'h1F02_405F_02, 40'h1F02_201F_00,
    40'h1F02_100F_02, 40'h1F02_0817_02, 40'h1F02_041B_02, 40'h1F02_021D_02,
    40'h1F02_011E_02, 40'hC200_011E_02, 40'hC100_021D_02, 40'h1F02_110E_02,
    40'h1F02_811E_02};

  rcf_reset_cause_flags #(.HADDR_W(32)) DUT (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .causePowerOn(pulse[1]), .causeBrownout(pulse[0]),
    .causeWatchdog(pulse[4]), .causePin(pulse[3]), .causeInstr(pulse[2]),
    .causeMemViolation(pulse[5]), .stackOverflowEvent(pulse[7]),
    .stackUnderflowEvent(pulse[6]), .stackResetEnable(stackResetEnable),
    .brownoutModeConfig(modeCfg), .brownoutArmed(armed),
    .brownoutDetectorEnable(detEnable), .stackResetRequest(stackReq), .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [31:0] a, logic [7:0] d);
    @(posedge core_clk);
    hwrite <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
  endtask

  task automatic rdc(string what, logic [31:0] a, logic [31:0] exp);
    @(posedge core_clk);
    hwrite <= 1'b0;
    haddr <= a;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    chk(what, exp, hrdata);
  endtask

  task automatic fire(logic [7:0] v);
    @(posedge core_clk);
    pulse <= v;
    @(posedge core_clk);
    pulse <= 8'h00;
  endtask

  task automatic after_reset();
    rdc("main", A_MAIN, 32'h0000_001D);
    rdc("extra", A_EXTRA, 32'h0000_0002);
    rdc("control", A_CTRL, 32'h0000_0081);
    rdc("mask", A_MASK, 32'h0000_0000);
  endtask

  initial begin
    int         i;
    logic [1:0] m;
    logic       s;
    logic       e;
    resetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    pulse = 8'h00;
    stackResetEnable = 1'b1;
    modeCfg = `RCF_BOMODE_SOFTWARE;
    armed = 1'b1;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    after_reset();
    wr(A_MASK, 8'hFF);
    foreach (rows[k]) begin
      wr(A_MAIN, rows[k][39:32]);
      wr(A_EXTRA, rows[k][31:24]);
      fire(rows[k][23:16]);
      rdc("main", A_MAIN, {24'h00_0000, rows[k][15:8]});
      rdc("extra", A_EXTRA, {24'h00_0000, rows[k][7:0]});
      #1 chk("irq set", 32'h0000_0001, {31'h0, irq});
      rdc("status", A_STAT, {24'h00_0000, rows[k][23:16]});
      #1 chk("irq clear", 32'h0000_0000, {31'h0, irq});
    end
    wr(A_MAIN, 8'hC0);
    repeat (20) @(posedge core_clk);
    rdc("main held", A_MAIN, 32'h0000_00C0);
    wr(A_MASK, 8'hEF);
    fire(8'h10);
    repeat (2) @(posedge core_clk);
    #1 chk("irq masked", 32'h0000_0000, {31'h0, irq});
    fire(8'h08);
    repeat (2) @(posedge core_clk);
    #1 chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    rdc("status", A_STAT, 32'h0000_0018);
    for (i = 0; i < 8; i++) begin
      m = i[2:1];
      s = i[0];
      e = (m == 2'h0) ? 1'b0 : (m == 2'h1) ? s : 1'b1;
      modeCfg <= m;
      armed <= ~s;
      wr(A_CTRL, {s, 7'h01});
      #1 chk("detector", {31'h0, e}, {31'h0, detEnable});
      rdc("control", A_CTRL, {24'h00_0000, s, 6'h00, e & ~s});
    end
    modeCfg <= `RCF_BOMODE_SOFTWARE;
    armed <= 1'b1;
    wr(A_CTRL, 8'h00);
    fire(8'h10);
    rdc("enable kept", A_CTRL, 32'h0000_0000);
    fire(8'h01);
    rdc("enable reload", A_CTRL, 32'h0000_0081);
    wr(A_NONE, 8'hFF);
    rdc("unmapped", A_NONE, 32'h0000_0000);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    after_reset();
    stackResetEnable <= 1'b0;
    fire(8'hC0);
    rdc("stack flags", A_MAIN, 32'h0000_00DD);
    pulse <= 8'h40;
    #1 chk("stack gated", 32'h0000_0000, {31'h0, stackReq});
    @(posedge core_clk);
    stackResetEnable <= 1'b1;
    #1 chk("stack request", 32'h0000_0001, {31'h0, stackReq});
    chk("bus response", 32'h0000_0000, {31'h0, hresp});
    @(posedge core_clk);
    pulse <= 8'h00;
    end_sim();
  end
endmodule
